// ===== src/async_uart_receiver_wake.v
// Asynchronous serial receiver with nine-bit address filtering and wake on break edge.
// Assumes register-port signals and the receive line are synchronous to clk.
`timescale 1ns/1ps
`include "uart_rx_map.vh"

module async_uart_receiver_wake (
  input wire clk,
  input wire reset,
  input wire [3:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  input wire receiveLine,
  input wire sleepMode,
  output wire rxIrqHigh,
  output wire rxIrqLow
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_STOP = 3'h3;
  localparam [2:0] ST_WAKE = 3'h4;

  // ****************************************
  // Software-visible storage
  // ****************************************
  reg [7:0] irqEnables_ff;
  reg [7:0] irqPriority_ff;
  reg [7:3] rxCtl_ff;
  reg [7:0] txStatus_ff;
  reg [7:0] baudCtl_ff;
  reg [7:0] divHi_ff;
  reg [7:0] divLo_ff;
  reg [7:0] rxData_ff;
  reg ninthBit_ff;
  reg framingErr_ff;
  reg overrunErr_ff;
  reg bufFull_ff;
  reg wakeFlag_ff;

  // ****************************************
  // Receiver engine state
  // ****************************************
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [15:0] divCnt_ff;
  reg [1:0] preCnt_ff;
  reg [3:0] subCnt_ff;
  reg [3:0] bitCnt_ff;
  reg [1:0] votes_ff;
  reg [8:0] shift_ff;
  reg lineLast_ff;
  reg wakeArmed_ff;

  wire serialPortEnable = rxCtl_ff[`BIT_SERIAL_PORT_ENABLE];
  wire nineBitReceiveEnable = rxCtl_ff[`BIT_NINE_BIT_RECEIVE_ENABLE];
  wire continuousReceiveEnable = rxCtl_ff[`BIT_CONTINUOUS_RECEIVE_ENABLE];
  wire addressDetectEnable = rxCtl_ff[`BIT_ADDRESS_DETECT_ENABLE];
  wire wakeOnBreakEnable = baudCtl_ff[`BIT_WAKE_ON_BREAK_ENABLE];
  wire wideBaudCounterSelect = baudCtl_ff[`BIT_WIDE_BAUD_COUNTER_SELECT];
  wire highSpeedBaudSelect = txStatus_ff[`BIT_HIGH_SPEED_BAUD_SELECT];
  wire asyncMode = serialPortEnable & ~txStatus_ff[`BIT_CLOCKED_MODE];
  // Overrun stalls reception until software clears the enable
  wire rxRun = asyncMode & continuousReceiveEnable & ~wakeOnBreakEnable & ~sleepMode &
               ~overrunErr_ff;
  wire wakeMode = asyncMode & wakeOnBreakEnable;
  wire rxIrqFlag = bufFull_ff | wakeFlag_ff;

  wire wrSel = regWrite;
  wire rdBuf = regRead & (regAddr == `ADDR_RX_DATA);
  wire wrRxCtl = wrSel & (regAddr == `ADDR_RX_STATUS);
  wire wrBaud = wrSel & (regAddr == `ADDR_BAUD_CTRL);

  // ****************************************
  // Baud generator: one tick per sixteenth of a bit
  // ****************************************
  wire [15:0] divisor = wideBaudCounterSelect ? {divHi_ff, divLo_ff} : {8'h00, divLo_ff};
  // The slow setting divides by four more, since it is a x64 bit clock
  wire slowMode = ~wideBaudCounterSelect & ~highSpeedBaudSelect;
  wire divWrap = (divCnt_ff == divisor);
  wire tick = rxRun & divWrap & (~slowMode | (preCnt_ff == `PRESCALE_LAST));

  always @(posedge clk) begin
    if (reset) begin
      divCnt_ff <= `RST_DIV;
      preCnt_ff <= 2'h0;
    end else if (!rxRun) begin
      divCnt_ff <= `RST_DIV;
      preCnt_ff <= 2'h0;
    end else if (divWrap) begin
      divCnt_ff <= `RST_DIV;
      preCnt_ff <= preCnt_ff + 2'h1;
    end else begin
      divCnt_ff <= divCnt_ff + 16'h0001;
    end
  end

  // ****************************************
  // Majority vote over samples 7, 8 and 9
  // ****************************************
  wire voteNow = tick & (subCnt_ff == `SUB_VOTE_LAST);
  wire voted = (votes_ff[1] & votes_ff[0]) | (votes_ff[1] & receiveLine) |
               (votes_ff[0] & receiveLine);
  wire bitEnd = tick & (subCnt_ff == `SUB_BIT_END);
  wire [3:0] lastBit = nineBitReceiveEnable ? `LAST_BIT_9 : `LAST_BIT_8;

  always @(posedge clk) begin
    if (reset) begin
      votes_ff <= 2'h0;
    end else if (tick && subCnt_ff >= `SUB_VOTE_FIRST && subCnt_ff < `SUB_VOTE_LAST) begin
      votes_ff <= {votes_ff[0], receiveLine};
    end
  end

  // ****************************************
  // Character framing
  // ****************************************
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (wakeMode) begin
          nxt_state = ST_WAKE;
        end else if (rxRun && !receiveLine) begin
          nxt_state = ST_START;
        end
      end
      ST_START: begin
        if (voteNow && voted) begin
          nxt_state = ST_IDLE; // Glitch, not a start bit
        end else if (bitEnd) begin
          nxt_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (bitEnd && bitCnt_ff == lastBit) begin
          nxt_state = ST_STOP;
        end
      end
      ST_STOP: begin
        // Return at mid stop bit so the next start edge is not missed
        if (voteNow) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WAKE: begin
        if (!wakeMode) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (!rxRun && !wakeMode) begin
      nxt_state = ST_IDLE;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      subCnt_ff <= 4'h0;
      bitCnt_ff <= 4'h0;
      shift_ff <= 9'h000;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE) begin
        subCnt_ff <= 4'h0;
        bitCnt_ff <= 4'h0;
      end else if (tick) begin
        subCnt_ff <= subCnt_ff + 4'h1;
        if (bitEnd && state_ff == ST_DATA) begin
          bitCnt_ff <= bitCnt_ff + 4'h1;
        end
      end
      if (voteNow && state_ff == ST_DATA) begin
        // Bits enter at the top and move down: first bit ends at bit 0
        if (nineBitReceiveEnable) begin
          shift_ff <= {voted, shift_ff[8:1]};
        end else begin
          shift_ff <= {1'b0, voted, shift_ff[7:1]};
        end
      end
    end
  end

  // ****************************************
  // Completion, filtering and error flags
  // ****************************************
  wire charDone = voteNow & (state_ff == ST_STOP);
  wire ninthNow = nineBitReceiveEnable & shift_ff[8];
  wire filtered = addressDetectEnable & nineBitReceiveEnable & ~shift_ff[8];
  wire accept = charDone & ~filtered;
  wire overrun = accept & bufFull_ff & ~rdBuf;
  wire load = accept & ~overrun;

  always @(posedge clk) begin
    if (reset) begin
      rxData_ff <= `RST_BYTE;
      ninthBit_ff <= 1'b0;
      framingErr_ff <= 1'b0;
      overrunErr_ff <= 1'b0;
      bufFull_ff <= 1'b0;
    end else begin
      if (load) begin
        rxData_ff <= shift_ff[7:0];
        ninthBit_ff <= ninthNow;
        framingErr_ff <= ~voted;
      end else if (!continuousReceiveEnable) begin
        framingErr_ff <= 1'b0;
      end
      if (overrun) begin
        overrunErr_ff <= 1'b1;
      end else if (!continuousReceiveEnable) begin
        overrunErr_ff <= 1'b0;
      end
      // A load in the cycle of a read keeps the buffer full
      if (load) begin
        bufFull_ff <= 1'b1;
      end else if (rdBuf) begin
        bufFull_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Wake on break edge
  // ****************************************
  wire fallEdge = lineLast_ff & ~receiveLine;
  wire riseEdge = ~lineLast_ff & receiveLine;
  // Arming keeps later falling edges of the break from counting as new wake-ups
  wire wakeEvent = wakeMode & ~wakeArmed_ff & fallEdge;
  wire wakeDone = wakeMode & wakeArmed_ff & riseEdge;

  // Edge sensing uses clk, which keeps running in sleep; reception does not
  always @(posedge clk) begin
    if (reset) begin
      lineLast_ff <= 1'b1;
      wakeArmed_ff <= 1'b0;
      wakeFlag_ff <= 1'b0;
    end else begin
      lineLast_ff <= receiveLine;
      if (wakeEvent) begin
        wakeArmed_ff <= 1'b1;
      end else if (wakeDone || !wakeMode) begin
        wakeArmed_ff <= 1'b0;
      end
      if (wakeEvent) begin
        wakeFlag_ff <= 1'b1;
      end else if (rdBuf) begin
        wakeFlag_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      irqEnables_ff <= `RST_BYTE;
      irqPriority_ff <= `RST_BYTE;
      rxCtl_ff <= `RST_CTL5;
      txStatus_ff <= `RST_BYTE;
      baudCtl_ff <= `RST_BYTE;
      divHi_ff <= `RST_BYTE;
      divLo_ff <= `RST_BYTE;
    end else begin
      if (wrSel && regAddr == `ADDR_IRQ_ENABLES) begin
        irqEnables_ff <= regWrData;
      end
      if (wrSel && regAddr == `ADDR_IRQ_PRIORITY) begin
        irqPriority_ff <= regWrData;
      end
      if (wrRxCtl) begin
        rxCtl_ff <= regWrData[7:3];
      end
      if (wrSel && regAddr == `ADDR_TX_STATUS) begin
        txStatus_ff <= regWrData;
      end
      // A software write wins over the hardware clear in the same cycle
      if (wrBaud) begin
        baudCtl_ff <= regWrData;
      end else if (wakeDone) begin
        baudCtl_ff[`BIT_WAKE_ON_BREAK_ENABLE] <= 1'b0;
      end
      if (wrSel && regAddr == `ADDR_BAUD_DIV_HI) begin
        divHi_ff <= regWrData;
      end
      if (wrSel && regAddr == `ADDR_BAUD_DIV_LO) begin
        divLo_ff <= regWrData;
      end
    end
  end

  // ****************************************
  // Register reads, data in the next cycle
  // ****************************************
  reg [7:0] rdMux;
  always @* begin
    rdMux = `RST_BYTE;
    case (regAddr)
      `ADDR_IRQ_FLAGS: rdMux[`BIT_RX_IRQ] = rxIrqFlag;
      `ADDR_IRQ_ENABLES: rdMux = irqEnables_ff;
      `ADDR_IRQ_PRIORITY: rdMux = irqPriority_ff;
      `ADDR_RX_STATUS: begin
        rdMux = {rxCtl_ff, framingErr_ff, overrunErr_ff, ninthBit_ff};
      end
      `ADDR_RX_DATA: rdMux = rxData_ff;
      `ADDR_TX_STATUS: begin
        rdMux = txStatus_ff;
        // No transmitter here, so the shifter always reads empty
        rdMux[`BIT_SHIFTER_EMPTY] = 1'b1;
      end
      `ADDR_BAUD_CTRL: begin
        rdMux = baudCtl_ff;
        // Idle is live state; the stored copy of that bit is never shown
        rdMux[`BIT_RECEIVER_IDLE] = (state_ff == ST_IDLE) | (state_ff == ST_WAKE);
      end
      `ADDR_BAUD_DIV_HI: rdMux = divHi_ff;
      `ADDR_BAUD_DIV_LO: rdMux = divLo_ff;
      default: rdMux = `RST_BYTE;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      regRdData <= `RST_BYTE;
    end else if (regRead) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= `RST_BYTE;
    end
  end

  // ****************************************
  // Interrupt request steering
  // ****************************************
  wire rxReq = rxIrqFlag & irqEnables_ff[`BIT_RX_IRQ];
  assign rxIrqHigh = rxReq & irqPriority_ff[`BIT_RX_IRQ];
  assign rxIrqLow = rxReq & ~irqPriority_ff[`BIT_RX_IRQ];

endmodule

// ===== src/uart_rx_map.vh
// Register map, field positions, reset values and timing points of the receiver.
// Assumes inclusion by the receiver module and its checker; definitions only.
`ifndef UART_RX_MAP_VH
`define UART_RX_MAP_VH

// ****************************************
// Register addresses (4-bit register port)
// ****************************************
`define ADDR_IRQ_FLAGS 4'h0
`define ADDR_IRQ_ENABLES 4'h1
`define ADDR_IRQ_PRIORITY 4'h2
`define ADDR_RX_STATUS 4'h3
`define ADDR_RX_DATA 4'h4
`define ADDR_TX_STATUS 4'h5
`define ADDR_BAUD_CTRL 4'h6
`define ADDR_BAUD_DIV_HI 4'h7
`define ADDR_BAUD_DIV_LO 4'h8

// ****************************************
// Field positions
// ****************************************
`define BIT_RX_IRQ 5
`define BIT_SERIAL_PORT_ENABLE 7
`define BIT_NINE_BIT_RECEIVE_ENABLE 6
`define BIT_CONTINUOUS_RECEIVE_ENABLE 4
`define BIT_ADDRESS_DETECT_ENABLE 3
`define BIT_FRAMING_ERROR_FLAG 2
`define BIT_OVERRUN_ERROR_FLAG 1
`define BIT_RECEIVED_NINTH_BIT 0
`define BIT_CLOCKED_MODE 4
`define BIT_HIGH_SPEED_BAUD_SELECT 2
`define BIT_SHIFTER_EMPTY 1
`define BIT_RECEIVER_IDLE 6
`define BIT_WIDE_BAUD_COUNTER_SELECT 3
`define BIT_WAKE_ON_BREAK_ENABLE 1

// ****************************************
// Reset values
// ****************************************
`define RST_BYTE 8'h00
`define RST_DIV 16'h0000
`define RST_CTL5 5'h00

// ****************************************
// Oversampling points within one bit (16 ticks)
// ****************************************
`define SUB_VOTE_FIRST 4'h7
`define SUB_VOTE_LAST 4'h9
`define SUB_BIT_END 4'hF
`define PRESCALE_LAST 2'h3
`define LAST_BIT_8 4'h7
`define LAST_BIT_9 4'h8

`endif

// ===== test/uart_line_model.sv
// Remote transmitter model driving the receive line.
// Assumes a free-running clk; one bit lasts BIT_CLKS cycles.
`timescale 1ns/1ps
module uart_line_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  output logic line
);
  initial line = 1'h1;
  task automatic hold(input logic lvl, input int n);
    line <= lvl;
    repeat (n) @(posedge clk);
  endtask
  // *****
  // Frame; a low stop is cut short so no false start follows
  // *****
  task automatic sendChar(input logic [8:0] d, input int nBits, input logic stopBit);
    @(posedge clk);
    hold(1'h0, BIT_CLKS);
    for (int i = 0; i < nBits; i++) hold(d[i], BIT_CLKS);
    if (stopBit) hold(1'h1, BIT_CLKS);
    else begin
      hold(1'h0, BIT_CLKS / 2 + 2);
      hold(1'h1, BIT_CLKS / 2);
    end
    hold(1'h1, BIT_CLKS);
  endtask
endmodule

// ===== test/uart_rx_asserts.sv
// Checker of the register port and request outputs.
// Assumes it is bound to the receiver top and sees its ports only.
`timescale 1ns/1ps
`include "uart_rx_map.vh"
module uart_rx_asserts (
  input wire clk,
  input wire reset,
  input wire [3:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdData,
  input wire rxIrqHigh,
  input wire rxIrqLow
);
  // *****
  // Shadows of enable and priority, the flag cannot be seen
  // *****
  reg en_ff;
  reg pri_ff;
  wire anyIrq = rxIrqHigh | rxIrqLow;
  always @(posedge clk) begin
    if (reset) begin
      en_ff <= 1'h0;
      pri_ff <= 1'h0;
    end else if (regWrite && regAddr == `ADDR_IRQ_ENABLES) begin
      en_ff <= regWrData[`BIT_RX_IRQ];
    end else if (regWrite && regAddr == `ADDR_IRQ_PRIORITY) begin
      pri_ff <= regWrData[`BIT_RX_IRQ];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_RD_IDLE: assert property (
    !regRead |=> regRdData == 8'h00) else $error("read data outside read");
  AST_UNMAPPED: assert property (
    regRead && regAddr > `ADDR_BAUD_DIV_LO |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_RESET: assert property (
    $fell(reset) |-> regRdData == 8'h00 && !anyIrq) else $error("not clear after reset");
  AST_ONE_LEVEL: assert property (
    !(rxIrqHigh && rxIrqLow)) else $error("both levels requested");
  AST_GATE: assert property (
    anyIrq |-> en_ff && rxIrqHigh == pri_ff) else $error("request level or gate wrong");
  AST_MASK: assert property (
    regWrite && regAddr == `ADDR_IRQ_ENABLES && !regWrData[`BIT_RX_IRQ] |=> !anyIrq)
    else $error("masked request still up");
  AST_MOVE: assert property (
    regWrite && regAddr == `ADDR_IRQ_PRIORITY && anyIrq
    |=> anyIrq && rxIrqHigh == $past(regWrData[`BIT_RX_IRQ])) else $error("request not moved");
  AST_HOLD: assert property (
    anyIrq && !regWrite && !regRead |=> anyIrq) else $error("request dropped by itself");
  AST_FLAG_RD: assert property (
    regRead && regAddr == `ADDR_IRQ_FLAGS && en_ff
    |=> regRdData[`BIT_RX_IRQ] == $past(anyIrq)) else $error("flag readback wrong");
  COV_HIGH: cover property (rxIrqHigh);
  COV_LOW: cover property (rxIrqLow);
  COV_DATA: cover property (regRead && regAddr == `ADDR_RX_DATA);
endmodule
bind async_uart_receiver_wake uart_rx_asserts chk (.clk(clk), .reset(reset),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .rxIrqHigh(rxIrqHigh), .rxIrqLow(rxIrqLow));

// ===== test/testbench.sv
// Self-checking bench of the receiver with a line model.
// Assumes divisor 0 and high speed, so one bit is 16 clocks.
`timescale 1ns/1ps
`define CHK(g, e) check(9'(g), 9'(e))
module testbench;
  logic clk, reset, regWrite, regRead, receiveLine, sleepMode, rxIrqHigh, rxIrqLow;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, v, d;
  logic [8:0] d9;
  int failures, checked, seed, rnd, i;
  async_uart_receiver_wake dut (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .receiveLine(receiveLine), .sleepMode(sleepMode),
    .rxIrqHigh(rxIrqHigh), .rxIrqLow(rxIrqLow));
  uart_line_model #(.BIT_CLKS(16)) peer (.clk(clk), .line(receiveLine));
  always #20 clk = ~clk;
  task check(input logic [8:0] g, input logic [8:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] expStat(input logic [7:0] c, input logic [8:0] x);
    return c | {7'h00, c[6] & x[8]};
  endfunction
  task wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk);
    regAddr <= a;
    regWrData <= x;
    regWrite <= 1'h1;
    @(posedge clk);
    regWrite <= 1'h0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clk);
    regRead <= 1'h0;
    #1 x = regRdData;
  endtask
  task rdChk(input logic [3:0] a, input logic [7:0] e);
    rd(a, v);
    `CHK(v, e);
  endtask
  task done(input string s);
    $display("test done: %s", s);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // *****
  // Watchdog: tests need about 3800 cycles
  // *****
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict;
  end
  initial begin
    clk = 1'h0;
    reset = 1'h1;
    {regAddr, regWrData, regWrite, regRead, sleepMode} = 0;
    failures = 0;
    checked = 0;
    seed = 32'h4144;
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    // Idle bit 6 of baud control is masked
    for (i = 0; i < 10; i++) begin
      rd(i[3:0], v);
      `CHK(v & (i == 6 ? 8'hBF : 8'hFF), i == 5 ? 8'h02 : 8'h00);
    end
    wr(4'h4, 8'hFF);
    rdChk(4'h4, 8'h00);
    wr(4'h5, 8'h04);
    wr(4'h1, 8'h20);
    wr(4'h2, 8'h20);
    wr(4'h3, 8'h90);
    done("reset values");
    for (i = 0; i < 6; i++) begin
      rnd = $random(seed);
      d = i == 0 ? 8'h00 : i == 1 ? 8'hFF : rnd[7:0];
      peer.sendChar({1'h0, d}, 8, 1'h1);
      `CHK(rxIrqHigh, 1'h1);
      rdChk(4'h3, 8'h90);
      rdChk(4'h4, d);
      `CHK(rxIrqHigh, 1'h0);
    end
    wr(4'h3, 8'hD0);
    for (i = 0; i < 3; i++) begin
      rnd = $random(seed);
      d9 = rnd[8:0];
      peer.sendChar(d9, 9, 1'h1);
      rdChk(4'h3, expStat(8'hD0, d9));
      rdChk(4'h4, d9[7:0]);
    end
    done("data");
    wr(4'h3, 8'hD8);
    peer.sendChar(9'h0AA, 9, 1'h1);
    `CHK(rxIrqHigh, 1'h0);
    peer.sendChar(9'h155, 9, 1'h1);
    rdChk(4'h3, 8'hD9);
    rdChk(4'h4, 8'h55);
    wr(4'h3, 8'hD0);
    peer.sendChar(9'h033, 9, 1'h1);
    rdChk(4'h4, 8'h33);
    done("address detect");
    wr(4'h3, 8'h90);
    peer.sendChar(9'h05A, 8, 1'h0);
    rdChk(4'h3, 8'h94);
    rdChk(4'h4, 8'h5A);
    peer.sendChar(9'h011, 8, 1'h1);
    peer.sendChar(9'h022, 8, 1'h1);
    rdChk(4'h3, 8'h92);
    rdChk(4'h4, 8'h11);
    wr(4'h3, 8'h80);
    rdChk(4'h3, 8'h80);
    done("errors");
    peer.sendChar(9'h0C3, 8, 1'h1);
    `CHK(rxIrqHigh, 1'h0);
    wr(4'h3, 8'h90);
    wr(4'h5, 8'h14);
    peer.sendChar(9'h0C3, 8, 1'h1);
    `CHK(rxIrqHigh, 1'h0);
    wr(4'h5, 8'h04);
    @(posedge clk) sleepMode <= 1'h1;
    peer.sendChar(9'h0C3, 8, 1'h1);
    `CHK(rxIrqHigh, 1'h0);
    @(posedge clk) sleepMode <= 1'h0;
    wr(4'h2, 8'h00);
    peer.sendChar(9'h03C, 8, 1'h1);
    `CHK({rxIrqHigh, rxIrqLow}, 2'h1);
    wr(4'h2, 8'h20);
    #1 `CHK({rxIrqHigh, rxIrqLow}, 2'h2);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h00);
    #1 `CHK(rxIrqLow, 1'h0);
    rdChk(4'h0, 8'h20);
    wr(4'h1, 8'h20);
    rdChk(4'h0, 8'h20);
    rdChk(4'h4, 8'h3C);
    done("gating");
    @(posedge clk) sleepMode <= 1'h1;
    wr(4'h6, 8'h02);
    fork
      peer.sendChar(9'h000, 8, 1'h1);
      begin
        repeat (40) @(posedge clk);
        #1 `CHK(rxIrqLow, 1'h1);
        rd(4'h6, v);
        `CHK(v[1], 1'h1);
      end
    join
    rd(4'h6, v);
    `CHK(v[1], 1'h0);
    @(posedge clk) sleepMode <= 1'h0;
    rd(4'h4, v);
    `CHK(rxIrqLow, 1'h0);
    done("wake");
    print_verdict;
  end
endmodule
